// >>> pssu_pkg.sv
// Purpose: Constants for the PHY summary status register, upper half.
// Assumes: Management reads arrive as one-cycle strobes with an address.
// Notes: Offsets are register numbers on the management port.
package pssu_pkg;
  localparam logic [4:0] PSSU_BASIC_STATUS_ADDR = 5'h01;
  localparam logic [4:0] PSSU_NEG_EXPANSION_ADDR = 5'h06;
  localparam logic [4:0] PSSU_SUMMARY_ADDR = 5'h10;
  localparam logic [4:0] PSSU_INT_STATUS_ADDR = 5'h12;
  localparam logic [4:0] PSSU_FALSE_CARRIER_ADDR = 5'h14;
  localparam logic [4:0] PSSU_RX_ERROR_ADDR = 5'h15;
  localparam logic [4:0] PSSU_TEN_MEG_STATUS_ADDR = 5'h1a;
  localparam int PSSU_BIT_RESERVED = 15;
  localparam int PSSU_BIT_CROSSOVER = 14;
  localparam int PSSU_BIT_RX_ERROR = 13;
  localparam int PSSU_BIT_POLARITY = 12;
  localparam int PSSU_BIT_FALSE_CARRIER = 11;
  localparam int PSSU_BIT_SIGNAL_DETECT = 10;
  localparam int PSSU_BIT_DESCR_LOCK = 9;
  localparam int PSSU_BIT_PAGE_RECEIVED = 8;
  localparam int PSSU_BIT_INT_PENDING = 7;
  localparam int PSSU_BIT_REMOTE_FAULT = 6;
  localparam logic [15:0] PSSU_SUMMARY_RESET = 16'h0000;
  localparam logic PSSU_FLAG_RESET = 1'b0;
endpackage

// >>> pssu_status.sv
// Purpose: Upper bits 15 to 6 of the PHY summary status register.
// Assumes: Event and level inputs come from logic on clk.
// Notes: Bits 5 to 0 read as zero here; they are merged elsewhere.
//
// Summary of operation
// - Summary register answers reads at 0x10.
// - Bit 15 reserved, always reads zero.
// - Bit 14 shows pair crossover state.
// - Crossover bit follows force and enable.
// - Bit 13 latches receive error, cleared reading 0x15.
// - Bit 12 latches inverted polarity, cleared reading ten-meg status.
// - Bit 11 latches false carrier, cleared reading 0x14.
// - Bit 10 signal detect, latching low.
// - Bit 9 descrambler lock, latching low.
// - Bit 8 page received, cleared reading 0x06.
// - Bit 7 shows pending interrupt.
// - Reading interrupt status clears pending bit.
// - Bit 6 remote fault, cleared reading 0x01.
`timescale 1ns/1ps
module pssu_status
  import pssu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rd_strobe,
  input wire logic [4:0] rd_addr,
  input wire logic auto_crossover_enable,
  input wire logic crossover_force,
  input wire logic crossover_auto_state,
  input wire logic rx_error_event,
  input wire logic polarity_inverted_event,
  input wire logic false_carrier_event,
  input wire logic signal_detect,
  input wire logic descrambler_locked,
  input wire logic page_received_event,
  input wire logic interrupt_event,
  input wire logic remote_fault_event,
  output logic [15:0] rd_data,
  output logic rd_valid
);
  // ****************************************
  // Read decode
  // ****************************************
  wire rd_summary = rd_strobe && (rd_addr == PSSU_SUMMARY_ADDR);
  wire rd_rx_err = rd_strobe && (rd_addr == PSSU_RX_ERROR_ADDR);
  wire rd_fcs = rd_strobe && (rd_addr == PSSU_FALSE_CARRIER_ADDR);
  wire rd_ten = rd_strobe && (rd_addr == PSSU_TEN_MEG_STATUS_ADDR);
  wire rd_negotiation_expansion_reg = rd_strobe && (rd_addr == PSSU_NEG_EXPANSION_ADDR);
  wire rd_int = rd_strobe && (rd_addr == PSSU_INT_STATUS_ADDR);
  wire rd_basic_status_reg = rd_strobe && (rd_addr == PSSU_BASIC_STATUS_ADDR);

  // Sticky flag: set wins over clear.
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // ****************************************
  // Flags
  // ****************************************
  logic crossover_r, rx_err_r, polarity_r, fcs_r, page_r, int_r, rf_r;
  logic sd_r, lock_r, sd_held_r, lock_held_r;
  wire crossover_nxt = crossover_force ? 1'b1 :
    (auto_crossover_enable ? crossover_auto_state : 1'b0);
  wire rx_err_nxt = sticky(rx_err_r, rx_error_event, rd_rx_err);
  wire polarity_nxt =
    sticky(polarity_r, polarity_inverted_event, rd_ten);
  wire fcs_nxt = sticky(fcs_r, false_carrier_event, rd_fcs);
  wire page_nxt = sticky(page_r, page_received_event, rd_negotiation_expansion_reg);
  wire int_nxt = sticky(int_r, interrupt_event, rd_int);
  wire rf_nxt = sticky(rf_r, remote_fault_event, rd_basic_status_reg);
  // Latching low: once low, hold low until summary read releases it.
  wire sd_held_nxt = (sd_held_r & ~rd_summary) | (sd_r & ~signal_detect);
  wire sd_nxt = sd_held_nxt ? 1'b0 : signal_detect;
  wire lock_held_nxt =
    (lock_held_r & ~rd_summary) | (lock_r & ~descrambler_locked);
  wire lock_nxt = lock_held_nxt ? 1'b0 : descrambler_locked;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crossover_r <= PSSU_FLAG_RESET;
      rx_err_r <= PSSU_FLAG_RESET;
      polarity_r <= PSSU_FLAG_RESET;
      fcs_r <= PSSU_FLAG_RESET;
      page_r <= PSSU_FLAG_RESET;
      int_r <= PSSU_FLAG_RESET;
      rf_r <= PSSU_FLAG_RESET;
      sd_r <= PSSU_FLAG_RESET;
      lock_r <= PSSU_FLAG_RESET;
      sd_held_r <= PSSU_FLAG_RESET;
      lock_held_r <= PSSU_FLAG_RESET;
    end else begin
      crossover_r <= crossover_nxt;
      rx_err_r <= rx_err_nxt;
      polarity_r <= polarity_nxt;
      fcs_r <= fcs_nxt;
      page_r <= page_nxt;
      int_r <= int_nxt;
      rf_r <= rf_nxt;
      sd_r <= sd_nxt;
      lock_r <= lock_nxt;
      sd_held_r <= sd_held_nxt;
      lock_held_r <= lock_held_nxt;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [15:0] summary_word;
  always_comb begin
    summary_word = PSSU_SUMMARY_RESET;
    summary_word[PSSU_BIT_RESERVED] = 1'b0;
    summary_word[PSSU_BIT_CROSSOVER] = crossover_r;
    summary_word[PSSU_BIT_RX_ERROR] = rx_err_r;
    summary_word[PSSU_BIT_POLARITY] = polarity_r;
    summary_word[PSSU_BIT_FALSE_CARRIER] = fcs_r;
    summary_word[PSSU_BIT_SIGNAL_DETECT] = sd_r;
    summary_word[PSSU_BIT_DESCR_LOCK] = lock_r;
    summary_word[PSSU_BIT_PAGE_RECEIVED] = page_r;
    summary_word[PSSU_BIT_INT_PENDING] = int_r;
    summary_word[PSSU_BIT_REMOTE_FAULT] = rf_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= PSSU_SUMMARY_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_summary;
      rd_data <= rd_summary ? summary_word : PSSU_SUMMARY_RESET;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_reserved;
    @(posedge clk) disable iff (!reset_n) rd_data[PSSU_BIT_RESERVED] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bit read as one.");

  property p_read_answer;
    @(posedge clk) disable iff (!reset_n)
      rd_summary |=> rd_valid && rd_data == $past(summary_word);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Summary read returned wrong data.");

  property p_idle_data;
    @(posedge clk) disable iff (!reset_n)
      !rd_summary |=> !rd_valid && rd_data == PSSU_SUMMARY_RESET;
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("Data shown without a summary read.");

  property p_force;
    @(posedge clk) disable iff (!reset_n) crossover_force |=> crossover_r;
  endproperty
  a_force: assert property (p_force)
    else $error("Forced crossover not shown.");

  property p_crossover_off;
    @(posedge clk) disable iff (!reset_n)
      !crossover_force && !auto_crossover_enable |=> !crossover_r;
  endproperty
  a_crossover_off: assert property (p_crossover_off)
    else $error("Crossover shown while disabled.");

  property p_auto;
    @(posedge clk) disable iff (!reset_n)
      auto_crossover_enable && !crossover_force
      |=> crossover_r == $past(crossover_auto_state);
  endproperty
  a_auto: assert property (p_auto)
    else $error("Crossover does not follow algorithm.");

  property p_rx_err;
    @(posedge clk) disable iff (!reset_n)
      rx_error_event |=> rx_err_r;
  endproperty
  a_rx_err: assert property (p_rx_err)
    else $error("Receive error not latched.");

  property p_rx_err_hold;
    @(posedge clk) disable iff (!reset_n)
      rx_err_r && !rd_rx_err |=> rx_err_r;
  endproperty
  a_rx_err_hold: assert property (p_rx_err_hold)
    else $error("Receive error lost without its read.");

  property p_rx_err_clr;
    @(posedge clk) disable iff (!reset_n)
      rd_rx_err && !rx_error_event |=> !rx_err_r;
  endproperty
  a_rx_err_clr: assert property (p_rx_err_clr)
    else $error("Receive error not cleared.");

  property p_polarity_hold;
    @(posedge clk) disable iff (!reset_n)
      polarity_r && rd_summary && !rd_ten |=> polarity_r;
  endproperty
  a_polarity_hold: assert property (p_polarity_hold)
    else $error("Polarity cleared by summary read.");

  property p_polarity_set;
    @(posedge clk) disable iff (!reset_n)
      polarity_inverted_event |=> polarity_r;
  endproperty
  a_polarity_set: assert property (p_polarity_set)
    else $error("Inverted polarity not shown.");

  property p_polarity_clr;
    @(posedge clk) disable iff (!reset_n)
      rd_ten && !polarity_inverted_event |=> !polarity_r;
  endproperty
  a_polarity_clr: assert property (p_polarity_clr)
    else $error("Polarity not cleared by its read.");

  property p_fcs_clr;
    @(posedge clk) disable iff (!reset_n)
      rd_fcs && !false_carrier_event |=> !fcs_r;
  endproperty
  a_fcs_clr: assert property (p_fcs_clr)
    else $error("False carrier not cleared.");

  property p_fcs_set;
    @(posedge clk) disable iff (!reset_n)
      false_carrier_event |=> fcs_r;
  endproperty
  a_fcs_set: assert property (p_fcs_set)
    else $error("False carrier not latched.");

  sequence s_sd_drop;
    sd_r && !signal_detect ##1 signal_detect && !rd_summary;
  endsequence
  property p_sd_latch;
    @(posedge clk) disable iff (!reset_n)
      s_sd_drop |=> !sd_r;
  endproperty
  a_sd_latch: assert property (p_sd_latch)
    else $error("Signal detect did not latch low.");

  property p_sd_low;
    @(posedge clk) disable iff (!reset_n)
      !signal_detect |=> !sd_r;
  endproperty
  a_sd_low: assert property (p_sd_low)
    else $error("Signal detect shown while source low.");

  property p_sd_release;
    @(posedge clk) disable iff (!reset_n)
      rd_summary && signal_detect |=> sd_r;
  endproperty
  a_sd_release: assert property (p_sd_release)
    else $error("Signal detect not released by read.");

  property p_lock_low;
    @(posedge clk) disable iff (!reset_n)
      !descrambler_locked |=> !lock_r;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("Lock shown while source low.");

  sequence s_lock_drop;
    lock_r && !descrambler_locked ##1 descrambler_locked && !rd_summary;
  endsequence
  property p_lock_latch;
    @(posedge clk) disable iff (!reset_n)
      s_lock_drop |=> !lock_r;
  endproperty
  a_lock_latch: assert property (p_lock_latch)
    else $error("Lock did not latch low.");

  property p_lock_release;
    @(posedge clk) disable iff (!reset_n)
      rd_summary && descrambler_locked |=> lock_r;
  endproperty
  a_lock_release: assert property (p_lock_release)
    else $error("Lock not released by read.");

  property p_page_hold;
    @(posedge clk) disable iff (!reset_n)
      page_r && !rd_negotiation_expansion_reg |=> page_r;
  endproperty
  a_page_hold: assert property (p_page_hold)
    else $error("Page received lost.");

  property p_page_set;
    @(posedge clk) disable iff (!reset_n)
      page_received_event |=> page_r;
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("Page received not shown.");

  property p_page_clr;
    @(posedge clk) disable iff (!reset_n)
      rd_negotiation_expansion_reg && !page_received_event |=> !page_r;
  endproperty
  a_page_clr: assert property (p_page_clr)
    else $error("Page received not cleared.");

  property p_int_clr;
    @(posedge clk) disable iff (!reset_n)
      rd_int && !interrupt_event |=> !int_r;
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("Pending interrupt not cleared.");

  property p_int_set;
    @(posedge clk) disable iff (!reset_n)
      interrupt_event |=> int_r;
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("Pending interrupt not shown.");

  property p_rf_clr;
    @(posedge clk) disable iff (!reset_n)
      rd_basic_status_reg && !remote_fault_event |=> !rf_r;
  endproperty
  a_rf_clr: assert property (p_rf_clr)
    else $error("Remote fault not cleared.");

  property p_rf_set;
    @(posedge clk) disable iff (!reset_n)
      remote_fault_event |=> rf_r;
  endproperty
  a_rf_set: assert property (p_rf_set)
    else $error("Remote fault not shown.");
endmodule

// >>> pssu_status_test.sv
// Purpose: Self-checking bench for the upper summary status bits.
// Assumes: Inputs change on the falling edge; outputs are registered.
// Notes: A cycle model predicts rd_valid and rd_data at every rising edge while reset_n is high.
`timescale 1ns/1ps
module pssu_status_test;
  import pssu_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rd_strobe = 1'b0;
  logic [4:0] rd_addr = 5'h00;
  logic auto_crossover_enable = 1'b0;
  logic crossover_force = 1'b0;
  logic crossover_auto_state = 1'b0;
  logic rx_error_event = 1'b0;
  logic polarity_inverted_event = 1'b0;
  logic false_carrier_event = 1'b0;
  logic signal_detect = 1'b0;
  logic descrambler_locked = 1'b0;
  logic page_received_event = 1'b0;
  logic interrupt_event = 1'b0;
  logic remote_fault_event = 1'b0;
  logic [15:0] rd_data;
  logic rd_valid;
  logic m_xo, m_rxe, m_pol, m_fc, m_sd, m_lk, m_sdh, m_lkh, m_pg, m_ir, m_rf;
  logic [15:0] exp_data = 16'h0000;
  logic exp_valid = 1'b0;
  logic [4:0] addrs [0:6];
  int failures = 0;
  int checked = 0;
  pssu_status pssu_status_i (.clk(clk), .reset_n(reset_n),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .auto_crossover_enable(auto_crossover_enable),
    .crossover_force(crossover_force),
    .crossover_auto_state(crossover_auto_state),
    .rx_error_event(rx_error_event),
    .polarity_inverted_event(polarity_inverted_event),
    .false_carrier_event(false_carrier_event),
    .signal_detect(signal_detect), .descrambler_locked(descrambler_locked),
    .page_received_event(page_received_event),
    .interrupt_event(interrupt_event),
    .remote_fault_event(remote_fault_event),
    .rd_data(rd_data), .rd_valid(rd_valid));
  always #5 clk = ~clk;
  // ********************************
  // Reference model and comparisons.
  // ********************************
  function logic hit(input logic [4:0] a);
    return rd_strobe && (rd_addr == a);
  endfunction
  function logic [15:0] word();
    return {1'b0, m_xo, m_rxe, m_pol, m_fc, m_sd, m_lk, m_pg, m_ir, m_rf,
      6'h00};
  endfunction
  task check_valid();
    checked++;
    if (rd_valid !== exp_valid) begin
      failures++;
      $display("wrong value at %0t: valid %b not %b", $time, rd_valid,
        exp_valid);
    end
  endtask
  task check_data(input logic [15:0] m);
    checked++;
    if ((rd_data & m) !== (exp_data & m)) begin
      failures++;
      $display("wrong value at %0t: data %h not %h", $time, rd_data,
        exp_data);
    end
  endtask
  always @(posedge clk) begin
    if (reset_n) begin
      check_valid();
      check_data(16'hf000);
      check_data(16'h0e00);
      check_data(16'h01ff);
    end
    if (!reset_n) begin
      {m_xo, m_rxe, m_pol, m_fc, m_sd, m_lk, m_sdh, m_lkh} <= 8'h00;
      {m_pg, m_ir, m_rf, exp_valid} <= 4'h0;
      exp_data <= PSSU_SUMMARY_RESET;
    end else begin
      m_xo <= crossover_force | (auto_crossover_enable & crossover_auto_state);
      m_rxe <= rx_error_event | (m_rxe & !hit(PSSU_RX_ERROR_ADDR));
      m_pol <= polarity_inverted_event |
        (m_pol & !hit(PSSU_TEN_MEG_STATUS_ADDR));
      m_fc <= false_carrier_event | (m_fc & !hit(PSSU_FALSE_CARRIER_ADDR));
      m_pg <= page_received_event | (m_pg & !hit(PSSU_NEG_EXPANSION_ADDR));
      m_ir <= interrupt_event | (m_ir & !hit(PSSU_INT_STATUS_ADDR));
      m_rf <= remote_fault_event | (m_rf & !hit(PSSU_BASIC_STATUS_ADDR));
      m_sdh <= (m_sd & !signal_detect) |
        (m_sdh & !hit(PSSU_SUMMARY_ADDR));
      m_lkh <= (m_lk & !descrambler_locked) |
        (m_lkh & !hit(PSSU_SUMMARY_ADDR));
      m_sd <= signal_detect & (!m_sdh | hit(PSSU_SUMMARY_ADDR));
      m_lk <= descrambler_locked & (!m_lkh | hit(PSSU_SUMMARY_ADDR));
      exp_valid <= hit(PSSU_SUMMARY_ADDR);
      exp_data <= hit(PSSU_SUMMARY_ADDR) ? word() : 16'h0000;
    end
  end
  // ********************************
  // Stimulus.
  // ********************************
  task cyc(input logic s, input logic [4:0] a);
    @(negedge clk);
    rd_strobe = s;
    rd_addr = a;
  endtask
  task set_events(input logic [5:0] v);
    {rx_error_event, polarity_inverted_event, false_carrier_event} = v[5:3];
    {page_received_event, interrupt_event, remote_fault_event} = v[2:0];
  endtask
  task final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1038));
    addrs = '{PSSU_BASIC_STATUS_ADDR, PSSU_NEG_EXPANSION_ADDR,
      PSSU_SUMMARY_ADDR, PSSU_INT_STATUS_ADDR, PSSU_FALSE_CARRIER_ADDR,
      PSSU_RX_ERROR_ADDR, PSSU_TEN_MEG_STATUS_ADDR};
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    cyc(1'b1, PSSU_SUMMARY_ADDR);
    {signal_detect, descrambler_locked} = 2'b11;
    cyc(1'b1, PSSU_SUMMARY_ADDR);
    cyc(1'b1, PSSU_RX_ERROR_ADDR);
    set_events(6'h3f);
    cyc(1'b1, PSSU_SUMMARY_ADDR);
    set_events(6'h00);
    for (int i = 0; i < 7; i++) begin
      cyc(1'b1, addrs[i]);
      cyc(1'b1, PSSU_SUMMARY_ADDR);
    end
    cyc(1'b0, 5'h00);
    {signal_detect, descrambler_locked} = 2'b00;
    cyc(1'b1, PSSU_SUMMARY_ADDR);
    {signal_detect, descrambler_locked} = 2'b11;
    repeat (3) cyc(1'b1, PSSU_SUMMARY_ADDR);
    for (int i = 0; i < 8; i++) begin
      cyc(1'b1, PSSU_SUMMARY_ADDR);
      {crossover_force, auto_crossover_enable, crossover_auto_state} = 3'(i);
    end
    set_events(6'h3f);
    cyc(1'b0, 5'h00);
    reset_n = 1'b0;
    cyc(1'b0, 5'h00);
    set_events(6'h00);
    reset_n = 1'b1;
    repeat (4000) begin
      cyc(($urandom % 3) == 0, (($urandom % 8) == 7) ? 5'($urandom) :
        addrs[$urandom % 7]);
      set_events({($urandom % 6) == 0, ($urandom % 6) == 0,
        ($urandom % 6) == 0, ($urandom % 6) == 0, ($urandom % 6) == 0,
        ($urandom % 6) == 0});
      signal_detect = ($urandom % 8) != 0;
      descrambler_locked = ($urandom % 8) != 0;
      crossover_force = ($urandom % 4) == 0;
      auto_crossover_enable = ($urandom % 2) == 1;
      crossover_auto_state = ($urandom % 2) == 1;
    end
    cyc(1'b0, 5'h00);
    cyc(1'b0, 5'h00);
    final_report();
  end
endmodule
